// File: hdl/tbrd_map.svh
// Register offsets, field positions and reset values of the tape decoder.
`ifndef TBRD_MAP_SVH
`define TBRD_MAP_SVH
`define TBRD_OFS_CTRL    8'h00
`define TBRD_OFS_DELAY   8'h04
`define TBRD_OFS_TONE    8'h08
`define TBRD_OFS_LEADER  8'h0C
`define TBRD_OFS_ADDR    8'h10
`define TBRD_OFS_STATUS  8'h14
`define TBRD_OFS_RXDATA  8'h18
`define TBRD_OFS_TXDATA  8'h1C
`define TBRD_CTRL_RX     0
`define TBRD_CTRL_TX     1
`define TBRD_CTRL_BLOCK  2
`define TBRD_RST_DELAY   8'h16
`define TBRD_RST_HALF    8'h1E
`define TBRD_RST_CYC     8'h10
`define TBRD_RST_LEADER  8'hFA
`define TBRD_BYTE_BITS   4'h8
`endif

// File: hdl/tbrd_pkg.sv
// Types shared by the tape burst ratio decoder.
package tbrd_pkg;
	// Receive sequencer states.
	typedef enum logic [2:0] {
		RX_IDLE, RX_WAIT_END, RX_WAIT_START, RX_BURST, RX_PAUSE, RX_DONE
	} tbrd_rx_type;
	// Record sequencer states.
	typedef enum logic [2:0] {
		TX_IDLE, TX_LEAD, TX_GAP, TX_WAIT, TX_BIT
	} tbrd_tx_type;
	// Whole state of the top module.
	typedef struct packed {
		logic        syncA;
		logic        syncB;
		logic        syncC;
		logic        pinLevel;
		tbrd_rx_type rxState;
		logic        rxPend;
		logic [7:0]  rxTick;
		logic [7:0]  rxDur;
		logic [3:0]  rxBits;
		logic [7:0]  rxShift;
		logic        blockMode;
		logic [7:0]  sampleDelay;
		logic [7:0]  halfPeriod;
		logic [7:0]  burstCycles;
		logic [7:0]  leaderLen;
		logic [15:0] addr;
		tbrd_tx_type txState;
		logic [7:0]  txHold;
		logic        txHoldFull;
		logic [7:0]  txShift;
		logic [3:0]  txBit;
		logic [1:0]  txThird;
		logic [7:0]  txHalf;
		logic [7:0]  txCycLeft;
		logic [7:0]  txLeadLeft;
		logic        txTone;
		logic        txOut;
		logic [31:0] prdata;
		logic        pslverr;
	} tbrd_state_type;
endpackage

// File: hdl/tbrd_top.sv
// Tape burst ratio codec: receive FIFO and the APB controlled top.
// Functional notes
// - Level change needs two agreeing samples.
// - Start mid-burst: wait burst end, next start.
// - Decrement signed count each burst sample.
// - Increment same count each pause sample.
// - Bit equals count sign after pause.
// - Shift bit in from top, clear count.
// - Eight bits per byte, counters preset first.
// - Next bit measured from detected burst start.
// - Sample interval set by delay count.
// - Tone, burst length, sampling are programmable.
// - Block record stops at page wrap.
// - Long leader tone precedes each block.
// - Bit thirds: tone, data, silence.
//
// Decided for this implementation: register access over APB and the register offsets.

// Receive byte FIFO built from flip-flops.
module tbrd_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset.
	input  wire logic             ref_clk,
	input  wire logic             rstn,
	// Fill side.
	input  wire logic             inValid,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  inReady,
	// Drain side.
	output logic                  outValid,
	input  wire logic             outReady,
	output logic [WIDTH-1:0]      outData
);
	localparam int AW = $clog2(DEPTH);
	// Whole state of the FIFO.
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wr;
		logic [AW-1:0]               rd;
		logic [AW:0]                 level;
	} tbrd_fifo_type;
	tbrd_fifo_type f_r;  // Registered state.
	tbrd_fifo_type f_nxt; // Next state.
	logic          push; // Write accepted.
	logic          pop;  // Read accepted.

	// Depth must be a power of two so the pointers wrap by themselves.
	if (DEPTH < 2 || (1 << AW) != DEPTH)
		$error("tbrd_fifo: DEPTH must be a power of two of at least 2.");

	assign inReady  = (f_r.level != (AW+1)'(DEPTH));
	assign outValid = (f_r.level != '0);
	assign outData  = f_r.mem[f_r.rd];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	// Pointer and occupancy update; full and empty come from the level.
	always_comb begin
		f_nxt = f_r;
		if (push) begin
			f_nxt.mem[f_r.wr] = inData;
			f_nxt.wr = f_r.wr + 1'b1;
		end
		if (pop) begin
			f_nxt.rd = f_r.rd + 1'b1;
		end
		f_nxt.level = f_r.level + (AW+1)'(push) - (AW+1)'(pop);
	end

	// State register.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			f_r <= '0;
		end else begin
			f_r <= f_nxt;
		end
	end
endmodule

// Tone burst recorder and ratio decoder with an APB register file.
module tbrd_top
	import tbrd_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
) (
	// Clock and reset.
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Tape pins.
	input  wire logic        serialInPin,
	output logic             serialOutPin
);
`include "tbrd_map.svh"
	tbrd_state_type s_r;    // Registered state.
	tbrd_state_type s_nxt;  // Next state.
	logic           tick;   // One sample period has elapsed.
	logic [7:0]     durInc; // Duration count plus one.
	logic           txDone; // Current burst or silence ends now.
	logic           wrEn;   // APB write completes.
	logic           rdEn;   // APB read completes.
	logic           fifoReady;
	logic           fifoValid;
	logic [7:0]     fifoData;

	// Start a burst of the programmed length, with or without tone.
	function automatic tbrd_state_type startBurst(tbrd_state_type st,
			logic tone);
		tbrd_state_type r;
		r = st;
		r.txTone    = tone;
		r.txOut     = 1'b0;
		r.txHalf    = st.halfPeriod;
		r.txCycLeft = (st.burstCycles == 8'h00) ? 8'h01 : st.burstCycles;
		return r;
	endfunction

	assign tick   = (s_r.rxTick == 8'h00);
	assign durInc = s_r.rxDur + 8'h01;
	assign txDone = (s_r.txCycLeft == 8'h01) && (s_r.txHalf == 8'h00);
	assign wrEn   = psel && penable && pwrite;
	assign rdEn   = psel && penable && !pwrite;
	// Zero wait states: every access phase completes at once.
	assign pready       = psel && penable;
	assign prdata       = s_r.prdata;
	assign pslverr      = s_r.pslverr && psel && penable;
	assign serialOutPin = s_r.txOut;

	// Received bytes wait here until software reads them.
	tbrd_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rxFifo (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.inValid (s_r.rxState == RX_DONE),
		.inData  (s_r.rxShift),
		.inReady (fifoReady),
		.outValid(fifoValid),
		.outReady(rdEn && paddr == `TBRD_OFS_RXDATA),
		.outData (fifoData)
	);

	// All next-state logic: sync, receiver, recorder and registers.
	always_comb begin
		s_nxt = s_r;
		// Pin sync; the level moves only once the later stages agree.
		s_nxt.syncA = serialInPin;
		s_nxt.syncB = s_r.syncA;
		s_nxt.syncC = s_r.syncB;
		if (s_r.syncB == s_r.syncC) begin
			s_nxt.pinLevel = s_r.syncC;
		end
		// Sample timer reloads from the delay count.
		s_nxt.rxTick = tick ? s_r.sampleDelay : s_r.rxTick - 8'h01;

		// Receiver: every level change needs two agreeing samples.
		case (s_r.rxState)
			RX_IDLE: begin
				s_nxt.rxPend = 1'b0;
			end
			RX_WAIT_END: begin
				if (tick) begin
					s_nxt.rxPend = !s_r.pinLevel;
					if (!s_r.pinLevel && s_r.rxPend) begin
						s_nxt.rxState = RX_WAIT_START;
						s_nxt.rxPend  = 1'b0;
					end
				end
			end
			RX_WAIT_START: begin
				if (tick) begin
					s_nxt.rxPend = s_r.pinLevel;
					if (s_r.pinLevel && s_r.rxPend) begin
						s_nxt.rxState = RX_BURST;
						s_nxt.rxPend  = 1'b0;
					end
				end
			end
			RX_BURST: begin
				if (tick) begin
					s_nxt.rxDur  = s_r.rxDur - 8'h01;
					s_nxt.rxPend = !s_r.pinLevel;
					if (!s_r.pinLevel && s_r.rxPend) begin
						s_nxt.rxState = RX_PAUSE;
						s_nxt.rxPend  = 1'b0;
					end
				end
			end
			RX_PAUSE: begin
				if (tick) begin
					s_nxt.rxDur  = durInc;
					s_nxt.rxPend = s_r.pinLevel;
					if (s_r.pinLevel && s_r.rxPend) begin
						// Burst longer than pause leaves the count negative.
						s_nxt.rxShift = {durInc[7], s_r.rxShift[7:1]};
						s_nxt.rxDur   = 8'h00;
						s_nxt.rxPend  = 1'b0;
						s_nxt.rxBits  = s_r.rxBits - 4'h1;
						// The burst just seen already starts the next bit.
						s_nxt.rxState = (s_r.rxBits == 4'h1) ?
							RX_DONE : RX_BURST;
					end
				end
			end
			RX_DONE: begin
				// A full FIFO stalls the receiver here.
				if (fifoReady) begin
					s_nxt.rxBits = `TBRD_BYTE_BITS;
					s_nxt.rxDur  = 8'h00;
					s_nxt.rxState = RX_IDLE;
					if (s_r.blockMode) begin
						s_nxt.addr = s_r.addr + 16'h0001;
						if (s_r.addr[7:0] != 8'hFF) begin
							s_nxt.rxState = RX_WAIT_END;
						end
					end
				end
			end
			default: begin
				s_nxt.rxState = RX_IDLE;
			end
		endcase

		// Tone engine: toggles the pin every half period during tone.
		if (s_r.txCycLeft != 8'h00) begin
			s_nxt.txHalf = s_r.txHalf - 8'h01;
			if (s_r.txHalf == 8'h00) begin
				s_nxt.txHalf    = s_r.halfPeriod;
				s_nxt.txCycLeft = s_r.txCycLeft - 8'h01;
				s_nxt.txOut     = s_r.txTone && !s_r.txOut;
			end
		end

		// Recorder sequencer, advanced at the end of each burst slot; TX_WAIT instead leaves once a byte is held.
		case (s_r.txState)
			TX_IDLE: begin
				s_nxt.txOut = 1'b0;
			end
			TX_LEAD: begin
				if (txDone) begin
					if (s_r.txLeadLeft <= 8'h01) begin
						s_nxt = startBurst(s_nxt, 1'b0);
						s_nxt.txState = TX_GAP;
					end else begin
						s_nxt = startBurst(s_nxt, 1'b1);
						s_nxt.txLeadLeft = s_r.txLeadLeft - 8'h01;
					end
				end
			end
			TX_GAP: begin
				if (txDone) begin
					s_nxt.txState = TX_WAIT;
				end
			end
			TX_WAIT: begin
				// Silence is held while software has no byte ready.
				if (s_r.txHoldFull) begin
					s_nxt.txShift    = s_r.txHold;
					s_nxt.txHoldFull = 1'b0;
					s_nxt.txBit      = 4'h0;
					s_nxt.txThird    = 2'h0;
					s_nxt = startBurst(s_nxt, 1'b1);
					s_nxt.txState = TX_BIT;
				end
			end
			TX_BIT: begin
				if (txDone) begin
					if (s_r.txThird == 2'h0) begin
						// Zero fill makes the ninth bit a zero.
						s_nxt = startBurst(s_nxt, s_r.txShift[0]);
						s_nxt.txThird = 2'h1;
					end else if (s_r.txThird == 2'h1) begin
						s_nxt = startBurst(s_nxt, 1'b0);
						s_nxt.txThird = 2'h2;
					end else if (s_r.txBit == `TBRD_BYTE_BITS) begin
						s_nxt.addr = {s_r.addr[15:8], s_r.addr[7:0] + 8'h01};
						s_nxt.txState = (s_r.addr[7:0] == 8'hFF) ?
							TX_IDLE : TX_WAIT;
					end else begin
						s_nxt.txShift = {1'b0, s_r.txShift[7:1]};
						s_nxt.txBit   = s_r.txBit + 4'h1;
						s_nxt.txThird = 2'h0;
						s_nxt = startBurst(s_nxt, 1'b1);
					end
				end
			end
			default: begin
				s_nxt.txState = TX_IDLE;
			end
		endcase

		// Read data is captured in the setup phase.
		if (psel && !penable) begin
			s_nxt.pslverr = 1'b0;
			case (paddr)
				`TBRD_OFS_DELAY:  s_nxt.prdata = {24'h00_0000, s_r.sampleDelay};
				`TBRD_OFS_TONE:   s_nxt.prdata = {16'h0000, s_r.burstCycles,
					s_r.halfPeriod};
				`TBRD_OFS_LEADER: s_nxt.prdata = {24'h00_0000, s_r.leaderLen};
				`TBRD_OFS_ADDR:   s_nxt.prdata = {16'h0000, s_r.addr};
				`TBRD_OFS_STATUS: s_nxt.prdata = {24'h00_0000, s_r.pinLevel,
					fifoReady, fifoValid, s_r.txHoldFull,
					s_r.txState != TX_IDLE, s_r.rxState != RX_IDLE,
					s_r.blockMode, 1'b0};
				`TBRD_OFS_RXDATA: s_nxt.prdata = {24'h00_0000, fifoData};
				`TBRD_OFS_CTRL:   s_nxt.prdata = {29'h0000_0000,
					s_r.blockMode, 2'h0};
				`TBRD_OFS_TXDATA: s_nxt.prdata = {24'h00_0000, s_r.txHold};
				default: begin
					s_nxt.prdata  = 32'h0000_0000;
					s_nxt.pslverr = 1'b1;
				end
			endcase
		end

		// Writes take effect at the access edge; they win over hardware.
		if (wrEn) begin
			case (paddr)
				`TBRD_OFS_CTRL: begin
					s_nxt.blockMode = pwdata[`TBRD_CTRL_BLOCK];
					if (pwdata[`TBRD_CTRL_RX]) begin
						s_nxt.rxBits  = `TBRD_BYTE_BITS;
						s_nxt.rxDur   = 8'h00;
						s_nxt.rxPend  = 1'b0;
						s_nxt.rxState = RX_WAIT_END;
					end
					if (pwdata[`TBRD_CTRL_TX]) begin
						s_nxt = startBurst(s_nxt, 1'b1);
						s_nxt.txLeadLeft = s_r.leaderLen;
						s_nxt.txState    = TX_LEAD;
					end
				end
				`TBRD_OFS_DELAY:  s_nxt.sampleDelay = pwdata[7:0];
				`TBRD_OFS_TONE: begin
					s_nxt.halfPeriod  = pwdata[7:0];
					s_nxt.burstCycles = pwdata[15:8];
				end
				`TBRD_OFS_LEADER: s_nxt.leaderLen = pwdata[7:0];
				`TBRD_OFS_ADDR:   s_nxt.addr = pwdata[15:0];
				`TBRD_OFS_TXDATA: begin
					s_nxt.txHold     = pwdata[7:0];
					s_nxt.txHoldFull = 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	// State register with documented reset values.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s_r             <= '0;
			s_r.rxState     <= RX_IDLE;
			s_r.txState     <= TX_IDLE;
			s_r.sampleDelay <= `TBRD_RST_DELAY;
			s_r.halfPeriod  <= `TBRD_RST_HALF;
			s_r.burstCycles <= `TBRD_RST_CYC;
			s_r.leaderLen   <= `TBRD_RST_LEADER;
			s_r.rxBits      <= `TBRD_BYTE_BITS;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Checks on the receiver and recorder sequencing.
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	sequence sPauseSeen;
		s_r.rxState == RX_BURST && tick && !s_r.pinLevel && s_r.rxPend;
	endsequence
	sequence sBurstSeen;
		s_r.rxState == RX_PAUSE && tick && s_r.pinLevel && s_r.rxPend;
	endsequence
	a_rx_debounce: assert property (
		s_r.rxState == RX_BURST && s_nxt.rxState == RX_PAUSE |-> sPauseSeen)
		else $error("Pause accepted without two low samples.");
	a_burst_count: assert property (
		s_r.rxState == RX_BURST && tick |=> s_r.rxDur == $past(s_r.rxDur) - 8'h01)
		else $error("Burst sample did not decrement the count.");
	a_pause_count: assert property (
		s_r.rxState == RX_PAUSE && tick && !(s_r.pinLevel && s_r.rxPend)
		|=> s_r.rxDur == $past(durInc))
		else $error("Pause sample did not increment the count.");
	a_bit_sign: assert property (
		sBurstSeen |=> s_r.rxShift[7] == $past(durInc[7]) && s_r.rxDur == 8'h00)
		else $error("Decoded bit differs from the count sign.");
	a_next_bit: assert property (
		sBurstSeen ##0 s_r.rxBits != 4'h1 |=> s_r.rxState == RX_BURST)
		else $error("Next bit did not start from the detected burst.");
	a_wait_order: assert property (
		s_r.rxState == RX_WAIT_END |=> s_r.rxState inside
		{RX_WAIT_END, RX_WAIT_START, RX_IDLE})
		else $error("Receiver skipped waiting for the burst end.");
	a_byte_store: assert property (
		s_r.rxState == RX_DONE && !fifoReady |=> s_r.rxState == RX_DONE)
		else $error("Byte dropped while the FIFO was full.");
	a_page_stop: assert property (
		s_r.txState == TX_BIT && s_nxt.txState == TX_IDLE
		|=> s_r.addr[7:0] == 8'h00)
		else $error("Block record stopped away from the page end.");
	a_lead_gap: assert property (
		s_r.txState == TX_GAP |-> $past(s_r.txState) inside {TX_LEAD, TX_GAP})
		else $error("Gap reached without a leader tone.");
endmodule

// File: sim/tbrd_detector_model.sv
// Behavioural tone burst detector that turns recorded tone into a level.
module tbrd_detector_model #(
	parameter int HOLD = 6
) (
	// Clock.
	input  wire logic ref_clk,
	// Recorded tone and a noise request from the bench.
	input  wire logic tone,
	input  wire logic flip,
	// Detected envelope, high while tone is present.
	output logic      level
);
	timeunit 1ns;
	timeprecision 1ps;
	logic lastTone = 1'b0; // Tone seen one clock earlier.
	int   quiet    = HOLD; // Clocks since the last tone edge.
	// The envelope stays up a few clocks after the last edge, like a filter.
	always @(posedge ref_clk) begin
		lastTone <= tone;
		quiet    <= (tone != lastTone) ? 0 : ((quiet < HOLD) ? quiet + 1 : HOLD);
	end
	// Tone thirds become high, silent thirds low; noise flips the level.
	assign level = (quiet < HOLD) ^ flip;
endmodule

// File: sim/tbrd_tb.sv
// Self-checking bench: record through the detector and play back.
`include "tbrd_map.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// One row: byte recorded and byte that playback must return.
	typedef struct packed {
		logic [7:0] txByte;
		logic [7:0] rxByte;
	} tbrd_row_type;
	tbrd_row_type rows [16] = '{
		'{8'h00, 8'h00}, '{8'hFF, 8'hFF}, '{8'h01, 8'h01}, '{8'h80, 8'h80},
		'{8'h55, 8'h55}, '{8'hAA, 8'hAA}, '{8'h0F, 8'h0F}, '{8'hF0, 8'hF0},
		'{8'h96, 8'h96}, '{8'h69, 8'h69}, '{8'h7F, 8'h7F}, '{8'hFE, 8'hFE},
		'{8'h3C, 8'h3C}, '{8'hC3, 8'hC3}, '{8'h12, 8'h12}, '{8'hED, 8'hED}
	};
	// Register offsets and values expected right after reset.
	logic [7:0]  rstOfs [6] = '{`TBRD_OFS_CTRL, `TBRD_OFS_DELAY,
		`TBRD_OFS_TONE, `TBRD_OFS_LEADER, `TBRD_OFS_ADDR, `TBRD_OFS_STATUS};
	logic [31:0] rstVal [6] = '{32'h0000_0000, 32'(`TBRD_RST_DELAY),
		{16'h0000, `TBRD_RST_CYC, `TBRD_RST_HALF}, 32'(`TBRD_RST_LEADER),
		32'h0000_0000, 32'h0000_0040};
	logic        ref_clk;        // System clock.
	logic        rstn;           // Reset, active low.
	logic        psel;           // APB select.
	logic        penable;        // APB access phase.
	logic        pwrite;         // APB direction.
	logic [7:0]  paddr;          // APB address.
	logic [31:0] pwdata;         // APB write data.
	logic [31:0] prdata;         // APB read data.
	logic        pready;         // APB ready.
	logic        pslverr;        // APB error.
	logic        lineLevel;      // Detector output into the decoder.
	logic        toneOut;        // Square wave from the recorder side.
	logic        noisy  = 1'b0;  // Enables the noise source.
	logic        glitch = 1'b0;  // Two-clock flip of the detected level.
	int          cyc    = 0;     // Free running clock count.
	int          num_errors = 0; // Mismatches seen.
	int          compares   = 0; // Comparisons made.

	tbrd_top #(.FIFO_DEPTH(16)) u_tbrd_top (
		.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .serialInPin(lineLevel),
		.serialOutPin(toneOut));
	tbrd_detector_model #(.HOLD(6)) u_tbrd_detector_model (
		.ref_clk(ref_clk), .tone(toneOut), .flip(glitch), .level(lineLevel));

	// Clock of 4 ns period.
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// Noise source; two clocks of noise pass the pin filter as one sample
	// tick, so only the two-sample level check can reject them.
	always @(posedge ref_clk) begin
		cyc    <= cyc + 1;
		glitch <= noisy && (cyc % 37 < 2);
	end

	// Prints the counts and the verdict, then stops the run.
	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Compares one value and reports a mismatch at once.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One APB transfer; the request holds until pready is seen high.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			num_errors++;
			test_done();
		end
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// An idle edge keeps two requests from meeting in one time step.
		@(posedge ref_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0000_0000, r, e);
	endtask
	// Polls one status bit until it reaches a value, under a bound.
	task automatic waitBit(input int b, input logic v);
		logic [31:0] r;
		int          n;
		n = 0;
		do begin
			rd(`TBRD_OFS_STATUS, r);
			n++;
		end while (r[b] !== v && n < 5000);
		if (r[b] !== v) begin
			num_errors++;
			test_done();
		end
	endtask

	// Main sequence.
	initial begin
		logic [31:0] r;
		logic        e;
		int          started;
		int          sent;
		int          n;
		rstn    = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0000_0000;
		repeat (8) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		for (int i = 0; i < 6; i++) begin
			rd(rstOfs[i], r);
			chk(r, rstVal[i]);
		end
		// An unmapped place reads zero and answers with an error.
		apb(1'b0, 8'h20, 32'h0000_0000, r, e);
		chk(r, 32'h0000_0000);
		chk({31'h0, e}, 32'h0000_0001);
		$display("Reset and map test done");
		// Slot of 240 clocks in thirds of 80, one sample every 2 clocks: 40 per third.
		wr(`TBRD_OFS_DELAY, 32'h0000_0001);
		wr(`TBRD_OFS_TONE, 32'h0000_1403);
		wr(`TBRD_OFS_LEADER, 32'h0000_0003);
		wr(`TBRD_OFS_ADDR, 32'h0000_12F0);
		wr(`TBRD_OFS_TXDATA, {24'h0, rows[0].txByte});
		wr(`TBRD_OFS_CTRL, 32'h0000_0002);
		// Receive is started inside the leader, while tone is present.
		repeat (100) @(posedge ref_clk);
		started = 0;
		sent    = 1;
		n       = 0;
		while ((started < 16 || r[2]) && n < 20000) begin
			rd(`TBRD_OFS_STATUS, r);
			n++;
			if (!r[2] && started < 16) begin
				wr(`TBRD_OFS_CTRL, 32'h0000_0001);
				started++;
				r[2] = 1'b1;
			end
			if (!r[4] && sent < 16) begin
				wr(`TBRD_OFS_TXDATA, {24'h0, rows[sent].txByte});
				sent++;
			end
		end
		if (n >= 20000) begin
			num_errors++;
			test_done();
		end
		waitBit(3, 1'b0);
		rd(`TBRD_OFS_STATUS, r);
		chk(r & 32'h0000_006C, 32'h0000_0020);
		rd(`TBRD_OFS_ADDR, r);
		chk(r, 32'h0000_1200);
		$display("Block record and playback test done");
		// One byte under noise; the leader length is measured on the line.
		wr(`TBRD_OFS_ADDR, 32'h0000_00FF);
		wr(`TBRD_OFS_TXDATA, 32'h0000_0096);
		wr(`TBRD_OFS_CTRL, 32'h0000_0002);
		n = 0;
		while (lineLevel !== 1'b1 && n < 20) begin
			@(posedge ref_clk);
			n++;
		end
		n = 0;
		while (lineLevel === 1'b1 && n < 1000) begin
			@(posedge ref_clk);
			n++;
		end
		chk(32'(n >= 230 && n <= 250), 32'h0000_0001);
		wr(`TBRD_OFS_CTRL, 32'h0000_0001);
		noisy <= 1'b1;
		waitBit(3, 1'b0);
		noisy <= 1'b0;
		// The FIFO still holds the block, so the new byte waits in the
		// receiver until the first read frees a place.
		rd(`TBRD_OFS_STATUS, r);
		chk(r & 32'h0000_006C, 32'h0000_0024);
		for (int i = 0; i < 16; i++) begin
			rd(`TBRD_OFS_RXDATA, r);
			chk(r, {24'h0, rows[i].rxByte});
		end
		rd(`TBRD_OFS_RXDATA, r);
		chk(r, 32'h0000_0096);
		rd(`TBRD_OFS_STATUS, r);
		chk(r & 32'h0000_006C, 32'h0000_0040);
		rd(`TBRD_OFS_ADDR, r);
		chk(r, 32'h0000_0000);
		$display("Noise and leader test done");
		test_done();
	end
endmodule
